// >>> inc/mfecb_map.vh
/*
 * Register offsets, field positions and reset values of the meter front end
 * configuration bits.
 * Assumes inclusion by the single design file; it holds definitions only.
 */
`ifndef MFECB_MAP_VH
`define MFECB_MAP_VH

// ----------------------------------------------------------------------------
// Register indices; the byte address of each register is four times its index
// ----------------------------------------------------------------------------
`define MFECB_ADDR_ENGINE_CTRL 16'h2000
`define MFECB_ADDR_BANDGAP_SWAP 16'h2002
`define MFECB_ADDR_CONVERTER 16'h2005
`define MFECB_ADDR_BATTERY 16'h2020
`define MFECB_ADDR_BOOT_SIZE 16'h20a7
`define MFECB_ADDR_ENGINE_LOC 16'h20a8
`define MFECB_ADDR_CUR_MASTER 16'h20ab
`define MFECB_ADDR_CUR_AB 16'h20ac
`define MFECB_ADDR_CUR_CD 16'h20ad
`define MFECB_ADDR_WAKE_CTRL 16'h20f0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MFECB_BIT_ENGINE_FAST 3
`define MFECB_BIT_ENGINE_EN 4
`define MFECB_BIT_SWAP_MODE_LO 4
`define MFECB_BIT_CONVERTER_EN 3
`define MFECB_BIT_BATTERY_EN 6
`define MFECB_BIT_CUR_MASTER 0
`define MFECB_BIT_CUR_LO 0
`define MFECB_BIT_CUR_HI 4
`define MFECB_BIT_WAKE_STROBE 0

// ----------------------------------------------------------------------------
// Reset and wake values, chop modes, scale
// ----------------------------------------------------------------------------
`define MFECB_RST_BOOT_SIZE 8'h01
`define MFECB_RST_ENGINE_LOC 8'h31
`define MFECB_SWAP_TOGGLE_ALT 2'h0
`define MFECB_SWAP_POSITIVE 2'h1
`define MFECB_SWAP_REVERSED 2'h2
`define MFECB_SWAP_TOGGLE 2'h3
`define MFECB_KB_SHIFT 10
`define MFECB_FAST_KHZ 32'h0000_2710
`define MFECB_SLOW_KHZ 32'h0000_1388

`endif

// >>> rtl/mfecb_config_regs.v
/*
 * Configuration register bank of the meter front end: converter, battery
 * measurement, boot region, compute engine and chop controls, reached over
 * AXI4-Lite with 32-bit data and one aligned word per register, at four times its index.
 * Assumes one 125 MHz clock, an asynchronous active-low reset, and that the
 * multiplexer frame sync and end-of-interval marker are synchronous inputs.
 */
`include "mfecb_map.vh"
`timescale 1ns/1ps
`default_nettype none

module mfecb_config_regs #(
   parameter ADDR_W = 16
) (
   input wire clock_in,
   input wire rst_n_in,
   input wire [ADDR_W-1:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output reg s_axi_awready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output reg s_axi_wready_out,
   output reg [1:0] s_axi_bresp_out,
   output reg s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire [ADDR_W-1:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output reg s_axi_arready_out,
   output reg [31:0] s_axi_rdata_out,
   output reg [1:0] s_axi_rresp_out,
   output reg s_axi_rvalid_out,
   input wire s_axi_rready_in,
   input wire mux_frame_sync_in,
   input wire accumulation_interval_end_in,
   output reg converter_enable_out,
   output reg battery_load_out,
   output reg battery_route_out,
   output reg engine_enable_out,
   output reg engine_fast_clock_select_out,
   output reg [31:0] engine_clock_khz_out,
   output reg [17:0] boot_region_end_out,
   output reg [17:0] engine_program_start_out,
   output reg bandgap_swap_out,
   output reg alternate_frame_request_out,
   output reg [3:0] current_swap_out
);

   // ----------------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------------
   reg rst_meta_q;
   reg rst_sync_q;
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   wire rst_n = rst_sync_q;

   // ----------------------------------------------------------------------------
   // Configuration fields
   // ----------------------------------------------------------------------------
   reg converter_en_q;
   reg battery_en_q;
   reg [7:0] boot_size_q;
   reg engine_fast_q;
   reg engine_en_q;
   reg [7:0] engine_loc_q;
   reg [1:0] swap_mode_q;
   reg cur_master_q;
   reg [3:0] cur_swap_q;

   // ----------------------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------------------
   reg aw_held_q;
   reg w_held_q;
   reg [ADDR_W-1:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
   wire w_take = s_axi_wvalid_in && s_axi_wready_out;
   wire do_write = aw_held_q && w_held_q && !s_axi_bvalid_out;
   // An unaligned address is refused rather than folded onto a neighbour.
   wire [15:0] wr_idx = {2'b00, aw_addr_q[15:2]};
   wire wr_aligned = (aw_addr_q[1:0] == 2'b00);
   reg wr_hit;
   reg wake_pulse;

   always @* begin
      case (wr_idx)
         `MFECB_ADDR_ENGINE_CTRL,
         `MFECB_ADDR_BANDGAP_SWAP,
         `MFECB_ADDR_CONVERTER,
         `MFECB_ADDR_BATTERY,
         `MFECB_ADDR_BOOT_SIZE,
         `MFECB_ADDR_ENGINE_LOC,
         `MFECB_ADDR_CUR_MASTER,
         `MFECB_ADDR_CUR_AB,
         `MFECB_ADDR_CUR_CD,
         `MFECB_ADDR_WAKE_CTRL: wr_hit = wr_aligned;
         default: wr_hit = 1'b0;
      endcase
   end

   // Each register is its own aligned word, so its byte sits in lane 0.
   wire [7:0] wb = w_data_q[7:0];
   wire we0 = do_write && w_strb_q[0] && wr_hit;

   always @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= 2'h0;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= {ADDR_W{1'b0}};
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         s_axi_awready_out <= !aw_held_q && !aw_take;
         s_axi_wready_out <= !w_held_q && !w_take;
         if (aw_take) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_in;
         end
         if (w_take) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata_in;
            w_strb_q <= s_axi_wstrb_in;
         end
         if (do_write) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_hit ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Register updates
   // ----------------------------------------------------------------------------
   // Wake is a write-only strobe; it reloads the wake values but leaves the
   // battery enable alone, since its wake value is undefined.
   always @* begin
      wake_pulse = we0 && (wr_idx == `MFECB_ADDR_WAKE_CTRL)
         && wb[`MFECB_BIT_WAKE_STROBE];
   end

   always @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         converter_en_q <= 1'b0;
         battery_en_q <= 1'b0;
         boot_size_q <= `MFECB_RST_BOOT_SIZE;
         engine_fast_q <= 1'b0;
         engine_en_q <= 1'b0;
         engine_loc_q <= `MFECB_RST_ENGINE_LOC;
         swap_mode_q <= `MFECB_SWAP_TOGGLE_ALT;
         cur_master_q <= 1'b0;
         cur_swap_q <= 4'h0;
      end else if (wake_pulse) begin
         converter_en_q <= 1'b0;
         boot_size_q <= `MFECB_RST_BOOT_SIZE;
         engine_fast_q <= 1'b0;
         engine_en_q <= 1'b0;
         engine_loc_q <= `MFECB_RST_ENGINE_LOC;
         swap_mode_q <= `MFECB_SWAP_TOGGLE_ALT;
         cur_master_q <= 1'b0;
         cur_swap_q <= 4'h0;
      end else if (we0) begin
         case (wr_idx)
            `MFECB_ADDR_ENGINE_CTRL: begin
               engine_fast_q <= wb[`MFECB_BIT_ENGINE_FAST];
               engine_en_q <= wb[`MFECB_BIT_ENGINE_EN];
            end
            `MFECB_ADDR_BANDGAP_SWAP:
               swap_mode_q <= wb[`MFECB_BIT_SWAP_MODE_LO +: 2];
            `MFECB_ADDR_CONVERTER: converter_en_q <= wb[`MFECB_BIT_CONVERTER_EN];
            `MFECB_ADDR_BATTERY: battery_en_q <= wb[`MFECB_BIT_BATTERY_EN];
            `MFECB_ADDR_BOOT_SIZE: boot_size_q <= wb;
            `MFECB_ADDR_ENGINE_LOC: engine_loc_q <= wb;
            `MFECB_ADDR_CUR_MASTER: cur_master_q <= wb[`MFECB_BIT_CUR_MASTER];
            `MFECB_ADDR_CUR_AB: begin
               cur_swap_q[0] <= wb[`MFECB_BIT_CUR_LO];
               cur_swap_q[1] <= wb[`MFECB_BIT_CUR_HI];
            end
            `MFECB_ADDR_CUR_CD: begin
               cur_swap_q[2] <= wb[`MFECB_BIT_CUR_LO];
               cur_swap_q[3] <= wb[`MFECB_BIT_CUR_HI];
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------------------
   wire [15:0] rd_idx = {2'b00, s_axi_araddr_in[15:2]};
   reg [7:0] rd_byte;
   reg rd_hit;
   always @* begin
      rd_byte = 8'h00;
      rd_hit = (s_axi_araddr_in[1:0] == 2'b00);
      case (rd_idx)
         `MFECB_ADDR_ENGINE_CTRL: begin
            rd_byte[`MFECB_BIT_ENGINE_FAST] = engine_fast_q;
            rd_byte[`MFECB_BIT_ENGINE_EN] = engine_en_q;
         end
         `MFECB_ADDR_BANDGAP_SWAP: rd_byte[`MFECB_BIT_SWAP_MODE_LO +: 2] = swap_mode_q;
         `MFECB_ADDR_CONVERTER: rd_byte[`MFECB_BIT_CONVERTER_EN] = converter_en_q;
         `MFECB_ADDR_BATTERY: rd_byte[`MFECB_BIT_BATTERY_EN] = battery_en_q;
         `MFECB_ADDR_BOOT_SIZE: rd_byte = boot_size_q;
         `MFECB_ADDR_ENGINE_LOC: rd_byte = engine_loc_q;
         `MFECB_ADDR_CUR_MASTER: rd_byte[`MFECB_BIT_CUR_MASTER] = cur_master_q;
         `MFECB_ADDR_CUR_AB: begin
            rd_byte[`MFECB_BIT_CUR_LO] = cur_swap_q[0];
            rd_byte[`MFECB_BIT_CUR_HI] = cur_swap_q[1];
         end
         `MFECB_ADDR_CUR_CD: begin
            rd_byte[`MFECB_BIT_CUR_LO] = cur_swap_q[2];
            rd_byte[`MFECB_BIT_CUR_HI] = cur_swap_q[3];
         end
         `MFECB_ADDR_WAKE_CTRL: rd_byte = 8'h00;
         default: rd_hit = 1'b0;
      endcase
   end

   wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
   always @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= 2'h0;
      end else begin
         s_axi_arready_out <= !s_axi_rvalid_out && !ar_take;
         if (ar_take) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            s_axi_rresp_out <= rd_hit ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Bandgap chop sequencing
   // ----------------------------------------------------------------------------
   // The interval-end marker is latched so that the sync edge that closes the
   // interval, which may arrive later, is the one that skips the toggle.
   reg sync_prev_q;
   reg interval_end_q;
   wire sync_rise = mux_frame_sync_in && !sync_prev_q;

   always @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         sync_prev_q <= 1'b0;
         interval_end_q <= 1'b0;
         bandgap_swap_out <= 1'b0;
         alternate_frame_request_out <= 1'b0;
      end else begin
         sync_prev_q <= mux_frame_sync_in;
         if (sync_rise) begin
            interval_end_q <= accumulation_interval_end_in;
            alternate_frame_request_out <= 1'b0;
            case (swap_mode_q)
               `MFECB_SWAP_TOGGLE_ALT: begin
                  if (interval_end_q || accumulation_interval_end_in) begin
                     alternate_frame_request_out <= 1'b1;
                     interval_end_q <= 1'b0;
                  end else begin
                     bandgap_swap_out <= !bandgap_swap_out;
                  end
               end
               `MFECB_SWAP_POSITIVE: bandgap_swap_out <= 1'b0;
               `MFECB_SWAP_REVERSED: bandgap_swap_out <= 1'b1;
               `MFECB_SWAP_TOGGLE: bandgap_swap_out <= !bandgap_swap_out;
               default: bandgap_swap_out <= bandgap_swap_out;
            endcase
         end else if (accumulation_interval_end_in) begin
            interval_end_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Registered control outputs
   // ----------------------------------------------------------------------------
   always @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         converter_enable_out <= 1'b0;
         battery_load_out <= 1'b0;
         battery_route_out <= 1'b0;
         engine_enable_out <= 1'b0;
         engine_fast_clock_select_out <= 1'b0;
         engine_clock_khz_out <= 32'h0000_0000;
         boot_region_end_out <= 18'h00000;
         engine_program_start_out <= 18'h00000;
         current_swap_out <= 4'h0;
      end else begin
         converter_enable_out <= converter_en_q;
         battery_load_out <= battery_en_q;
         battery_route_out <= battery_en_q && alternate_frame_request_out;
         engine_enable_out <= engine_en_q;
         engine_fast_clock_select_out <= engine_fast_q;
         engine_clock_khz_out <= engine_en_q ?
            (engine_fast_q ? `MFECB_FAST_KHZ : `MFECB_SLOW_KHZ) : 32'h0000_0000;
         boot_region_end_out <= {boot_size_q, 10'h000};
         engine_program_start_out <= {engine_loc_q, 10'h000};
         current_swap_out <= cur_master_q ? cur_swap_q : 4'h0;
      end
   end

   // No display register lives here, so nothing has to survive the low-power
   // mode transitions; every field is held in ordinary flops.

endmodule

`default_nettype wire

// >>> tb/mfecb_config_regs_tb.sv
/*
 * Directed bench for the configuration register bank over AXI4-Lite.
 * Assumes a 125 MHz clock and the answer timing of the AXI slave as handed over.
 * The bus tasks take a register index; the byte address is four times the index.
 */
`timescale 1ns/1ps
`default_nettype none
module mfecb_config_regs_tb;
   logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, sync = 0, iend = 0;
   logic [15:0] awa = 0, ara = 0;
   logic [31:0] wd = 0;
   logic [3:0] ws = 0;
   wire awr, wrdy, bv, arr, rv, conv, bload, broute, een, efast, swap, alt;
   wire [1:0] br, rr;
   wire [31:0] rdat, khz;
   wire [17:0] bend, pstart;
   wire [3:0] cur;
   int num_errors = 0, n_tests = 0;
   logic [15:0] addr_t [9] = '{16'h2000, 16'h2002, 16'h2005, 16'h2020, 16'h20a7, 16'h20a8,
      16'h20ab, 16'h20ac, 16'h20ad};
   logic [7:0] rst_t [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h31, 8'h00, 8'h00, 8'h00};
   logic [7:0] mask_t [9] = '{8'h18, 8'h30, 8'h08, 8'h40, 8'hff, 8'hff, 8'h01, 8'h11, 8'h11};
   mfecb_config_regs mfecb_config_regs_i (.clock_in(clk), .rst_n_in(rst_n),
      .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
      .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rry), .mux_frame_sync_in(sync), .accumulation_interval_end_in(iend),
      .converter_enable_out(conv), .battery_load_out(bload), .battery_route_out(broute),
      .engine_enable_out(een), .engine_fast_clock_select_out(efast),
      .engine_clock_khz_out(khz), .boot_region_end_out(bend),
      .engine_program_start_out(pstart), .bandgap_swap_out(swap),
      .alternate_frame_request_out(alt), .current_swap_out(cur));
   // -------------------------------------------------------------------------
   // Bus and compare tasks.
   // -------------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      awa <= {a[13:0], 2'b00};
      wd <= {24'h000000, d};
      ws <= 4'h1;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
      end while (!bv && n < 40);
      bry <= 1'b0;
      if (n == 40) num_errors++;
      chk({30'h0, br}, {30'h0, er});
   endtask
   task automatic rdc(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      ara <= {a[13:0], 2'b00};
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arv && arr) arv <= 1'b0;
      end while (!rv && n < 40);
      rry <= 1'b0;
      if (n == 40) num_errors++;
      chk(rdat, {24'h000000, e});
      chk({30'h0, rr}, {30'h0, er});
   endtask
   // The interval end is raised one cycle ahead of the sync rise and dropped at it.
   task automatic pulse(input logic ie);
      @(posedge clk);
      iend <= ie;
      @(posedge clk);
      sync <= 1'b1;
      iend <= 1'b0;
      repeat (2) @(posedge clk);
      sync <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic summarize;
      $display("Checks: %0d, errors: %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial forever #4 clk = ~clk;
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      summarize();
   end
   // -------------------------------------------------------------------------
   // Test sequence.
   // -------------------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      for (int i = 0; i < 9; i++) rdc(addr_t[i], rst_t[i], 2'h0);
      chk({14'h0, bend}, 32'h00000400);
      chk({14'h0, pstart}, 32'h0000c400);
      rdc(16'h20f0, 8'h00, 2'h0);
      for (int i = 0; i < 9; i++) begin
         wr(addr_t[i], 8'hff, 2'h0);
         rdc(addr_t[i], mask_t[i], 2'h0);
      end
      repeat (3) @(posedge clk);
      chk({31'h0, conv}, 32'h1);
      chk({31'h0, bload}, 32'h1);
      chk(khz, 32'h00002710);
      chk({30'h0, een, efast}, 32'h3);
      chk({14'h0, bend}, 32'h0003fc00);
      chk({14'h0, pstart}, 32'h0003fc00);
      chk({28'h0, cur}, 32'h0000000f);
      wr(16'h20ab, 8'h00, 2'h0);
      wr(16'h2000, 8'h10, 2'h0);
      repeat (3) @(posedge clk);
      chk({28'h0, cur}, 32'h0);
      chk(khz, 32'h00001388);
      chk({30'h0, een, efast}, 32'h2);
      wr(16'h2000, 8'h00, 2'h0);
      wr(16'h2005, 8'h00, 2'h0);
      repeat (3) @(posedge clk);
      chk(khz, 32'h0);
      chk({31'h0, conv}, 32'h0);
      wr(16'h2002, 8'h10, 2'h0);
      pulse(1'b0);
      chk({31'h0, swap}, 32'h0);
      wr(16'h2002, 8'h20, 2'h0);
      repeat (4) @(posedge clk);
      chk({31'h0, swap}, 32'h0);
      pulse(1'b0);
      chk({31'h0, swap}, 32'h1);
      wr(16'h2002, 8'h30, 2'h0);
      pulse(1'b0);
      chk({31'h0, swap}, 32'h0);
      pulse(1'b1);
      chk({30'h0, swap, alt}, 32'h2);
      wr(16'h2002, 8'h00, 2'h0);
      pulse(1'b1);
      chk({30'h0, swap, alt}, 32'h3);
      chk({31'h0, broute}, 32'h1);
      pulse(1'b0);
      chk({30'h0, swap, alt}, 32'h0);
      chk({31'h0, broute}, 32'h0);
      wr(16'h2001, 8'hff, 2'h2);
      rdc(16'h2001, 8'h00, 2'h2);
      wr(16'h2005, 8'h08, 2'h0);
      wr(16'h20a7, 8'h42, 2'h0);
      wr(16'h20f0, 8'h01, 2'h0);
      rdc(16'h20a7, 8'h01, 2'h0);
      rdc(16'h20a8, 8'h31, 2'h0);
      rdc(16'h2005, 8'h00, 2'h0);
      rdc(16'h20f0, 8'h00, 2'h0);
      summarize();
   end
endmodule
`default_nettype wire

// >>> tb/mfecb_regs_sva.sv
/*
 * Checker for the configuration register bank: engine clock figure, battery
 * routing, frame-sync timing of the chop outputs and AXI answer timing.
 * Assumes it is bound to mfecb_config_regs and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module mfecb_regs_sva (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic mux_frame_sync_in,
   input wire logic battery_load_out,
   input wire logic battery_route_out,
   input wire logic engine_enable_out,
   input wire logic engine_fast_clock_select_out,
   input wire logic [31:0] engine_clock_khz_out,
   input wire logic [17:0] boot_region_end_out,
   input wire logic bandgap_swap_out,
   input wire logic alternate_frame_request_out
);
   // -------------------------------------------------------------------------
   // Cycles since the last rising edge of the frame sync, saturating at 7.
   // -------------------------------------------------------------------------
   logic sync_prev_q;
   logic [2:0] since_rise_q;
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_prev_q <= 1'b0;
         since_rise_q <= 3'h7;
      end else begin
         sync_prev_q <= mux_frame_sync_in;
         if (mux_frame_sync_in && !sync_prev_q) begin
            since_rise_q <= 3'h0;
         end else if (since_rise_q != 3'h7) begin
            since_rise_q <= since_rise_q + 3'h1;
         end
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   a_khz_fast: assert property (engine_enable_out && engine_fast_clock_select_out
      |-> engine_clock_khz_out == 32'h2710) else $error("engine clock not at fast rate");
   a_khz_slow: assert property (engine_enable_out && !engine_fast_clock_select_out
      |-> engine_clock_khz_out == 32'h1388) else $error("engine clock not at slow rate");
   a_route_needs_load: assert property (battery_route_out |-> battery_load_out)
      else $error("battery routed without load");
   a_boot_kb_units: assert property (boot_region_end_out[9:0] == 10'h000)
      else $error("boot end not a multiple of 1024");
   a_swap_on_sync: assert property ($changed(bandgap_swap_out) |-> since_rise_q == 3'h0)
      else $error("chop state changed away from a sync edge");
   a_alt_on_sync: assert property ($changed(alternate_frame_request_out)
      |-> since_rise_q == 3'h0) else $error("alternate request changed away from sync");
   a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
   a_resp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
endmodule
bind mfecb_config_regs mfecb_regs_sva mfecb_regs_sva_i (.clock_in(clock_in),
   .rst_n_in(rst_n_in), .s_axi_arvalid_in(s_axi_arvalid_in),
   .s_axi_arready_out(s_axi_arready_out), .s_axi_rvalid_out(s_axi_rvalid_out),
   .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
   .s_axi_bresp_out(s_axi_bresp_out), .mux_frame_sync_in(mux_frame_sync_in),
   .battery_load_out(battery_load_out), .battery_route_out(battery_route_out),
   .engine_enable_out(engine_enable_out),
   .engine_fast_clock_select_out(engine_fast_clock_select_out),
   .engine_clock_khz_out(engine_clock_khz_out), .boot_region_end_out(boot_region_end_out),
   .bandgap_swap_out(bandgap_swap_out),
   .alternate_frame_request_out(alternate_frame_request_out));
`default_nettype wire
